//--- rtl/scsm_pkg.sv
// constants and types for the system clock select and multiplier block
package scsm_pkg;

	// --------------------------------------------------------------
	// register map (byte addresses, one word each)
	// --------------------------------------------------------------
	localparam logic [7:0] ADDR_PMR = 8'h00; // power_mode_register
	localparam logic [7:0] ADDR_EXF = 8'h04; // extended_flag_register
	localparam logic [7:0] ADDR_IST = 8'h08; // interrupt status, read clears
	localparam logic [7:0] ADDR_IMK = 8'h0c; // interrupt mask

	// --------------------------------------------------------------
	// field positions
	// --------------------------------------------------------------
	localparam int PMR_SEL_HI  = 7; // clock_divide_select_hi
	localparam int PMR_SEL_LO  = 6; // clock_divide_select_lo
	localparam int PMR_ENA_BIT = 4; // multiplier_enable
	localparam int PMR_FAC_BIT = 3; // multiplier_factor_select
	localparam int EXF_RDY_BIT = 4; // multiplier_ready_flag
	localparam int EXF_RNG_BIT = 2; // ring_osc_active_flag
	localparam int IRQ_W       = 3; // number of event bits
	localparam int IRQ_RDY     = 0; // multiplier became ready
	localparam int IRQ_RNG     = 1; // switched back from ring oscillator
	localparam int IRQ_REJ     = 2; // select write refused

	// --------------------------------------------------------------
	// divide select encodings
	// --------------------------------------------------------------
	localparam logic [1:0] SEL_MULT = 2'h0; // frequency multiplier
	localparam logic [1:0] SEL_RSVD = 2'h1; // reserved, never accepted
	localparam logic [1:0] SEL_DIV4 = 2'h2; // divide-by-4, reset value
	localparam logic [1:0] SEL_SLOW = 2'h3; // slow_clock_mode

	// --------------------------------------------------------------
	// ratios and timing
	// --------------------------------------------------------------
	localparam int unsigned SLOW_DIV    = 256;   // slow source divide
	localparam int unsigned MULT_2X     = 2;     // factor select 0
	localparam int unsigned MULT_4X     = 4;     // factor select 1
	localparam logic [1:0]  MC_LAST     = 2'h3;  // last of four system ticks
	localparam int unsigned LOCK_CYCLES = 65536; // external clock cycles
	localparam int unsigned OSC_DIV_DEF = 16;    // hclk cycles per oscillator cycle
	localparam int          PER_W       = 24;    // system period counter width
	localparam logic [2:0]  HSIZE_WORD  = 3'h2;  // 32-bit transfer

	// --------------------------------------------------------------
	// multiplier engage sequence, one-hot
	// --------------------------------------------------------------
	typedef enum logic [3:0] {
		SEQ_IDLE  = 4'h1, // nothing in progress
		SEQ_ENCLR = 4'h2, // enable cleared in divide-by-4
		SEQ_FACT  = 4'h4, // factor written
		SEQ_ARMED = 4'h8  // enable set in order, lock running
	} scsm_seq_t;

endpackage

//--- rtl/scsm_tick_div.sv
// programmable tick divider, new period taken only at period end
`timescale 1ns/1ns
module scsm_tick_div #(
	parameter int W = 24
) (
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire logic [W-1:0] period,
	output logic              tick
);

	// --------------------------------------------------------------
	// state
	// --------------------------------------------------------------
	typedef struct packed {
		logic [W-1:0] cnt;  // cycles left in period
		logic         tick; // one-cycle pulse
	} scsm_div_t;

	scsm_div_t r;      // registered state
	scsm_div_t next_r; // next state

	// count down; reload only on wrap so no period is ever cut short
	always_comb begin
		next_r = r;
		next_r.tick = 1'b0;
		if (r.cnt == '0) begin // boundary: safe point to change length
			next_r.tick = 1'b1;
			next_r.cnt = period - W'(1);
		end else begin // mid period
			next_r.cnt = r.cnt - W'(1);
		end
	end

	// state register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign tick = r.tick;

endmodule

//--- rtl/scsm_lock_cnt.sv
// counts oscillator cycles after a start pulse, flags completion
`timescale 1ns/1ns
module scsm_lock_cnt #(
	parameter int unsigned COUNT = 65536
) (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic start,
	input  wire logic clear,
	input  wire logic step,
	output logic      busy,
	output logic      done,
	output logic      fin
);

	// --------------------------------------------------------------
	// state
	// --------------------------------------------------------------
	localparam int W = $clog2(COUNT + 1); // counter width

	typedef struct packed {
		logic         busy; // counting
		logic         done; // count reached, level
		logic         fin;  // count reached, pulse
		logic [W-1:0] cnt;  // cycles counted
	} scsm_lock_t;

	scsm_lock_t r;      // registered state
	scsm_lock_t next_r; // next state

	// clear beats start; start restarts a running count
	always_comb begin
		next_r = r;
		next_r.fin = 1'b0;
		if (clear) begin // abandon
			next_r.busy = 1'b0;
			next_r.done = 1'b0;
			next_r.cnt = '0;
		end else if (start) begin // begin a fresh count
			next_r.busy = 1'b1;
			next_r.done = 1'b0;
			next_r.cnt = '0;
		end else if (r.busy && step) begin // one oscillator cycle
			if (r.cnt == W'(COUNT - 1)) begin
				next_r.busy = 1'b0;
				next_r.done = 1'b1;
				next_r.fin = 1'b1;
				next_r.cnt = '0;
			end else begin
				next_r.cnt = r.cnt + W'(1);
			end
		end
	end

	// state register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign busy = r.busy;
	assign done = r.done;
	assign fin  = r.fin;

endmodule

//--- rtl/scsm_top.sv
// system clock source select, multiplier lock and machine-cycle tick
//
// How it works
// - select field picks oscillator, slow, or multiplier
// - machine tick every fourth system tick
// - timers run from system tick
// - select 00 uses multiplier, factor 2x/4x
// - clocks per cycle 2,1,-,4,1024
// - new rate applies next machine cycle
// - select changes only via divide-by-4
// - refused select write keeps old value
// - track engage order, refuse 00 otherwise
// - ready flag after 65536 oscillator cycles
// - multiplier engaged on following machine cycle
// - leaving multiplier needs only select write
// - ring flag clears after 65536 cycles
//
// Implementation choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
module scsm_top #(
	parameter int unsigned OSC_DIV     = scsm_pkg::OSC_DIV_DEF,
	parameter int unsigned LOCK_CYCLES = scsm_pkg::LOCK_CYCLES
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        ring_exit,
	output logic             osc_tick,
	output logic             sys_clk_tick,
	output logic             timer_base_tick,
	output logic             machine_tick,
	output logic [1:0]       clock_source_sel,
	output logic             multiplier_on,
	output logic             irq
);

	// --------------------------------------------------------------
	// state
	// --------------------------------------------------------------
	typedef struct packed {
		logic [1:0]              sel;       // select field as software sees it
		logic [1:0]              sel_eff;   // select in force on the clock
		logic                    factor;    // multiplier_factor_select
		logic                    mult_en;   // multiplier_enable
		scsm_pkg::scsm_seq_t     seq;       // engage sequence tracker
		logic [1:0]              mcnt;      // system ticks in machine cycle
		logic                    mach_tick; // machine cycle pulse
		logic [scsm_pkg::IRQ_W-1:0] ist;    // sticky events
		logic [scsm_pkg::IRQ_W-1:0] imask;  // interrupt mask
		logic                    irq;       // masked event level
		logic                    dp_wr;     // write data phase pending
		logic [7:0]              dp_addr;   // address of pending write
		logic [31:0]             rdata;     // read data register
	} scsm_state_t;

	scsm_state_t r;      // registered state
	scsm_state_t next_r; // next state

	localparam int PER_W_L = scsm_pkg::PER_W; // period width

	logic             sys_tick;  // system clock tick from divider
	logic             rdy_done;  // multiplier_ready_flag
	logic             rdy_fin;   // ready just reached
	logic             rdy_start; // start lock count
	logic             rdy_clear; // abandon lock count
	logic             ring_busy; // ring_osc_active_flag
	logic             ring_fin;  // switched back to oscillator
	logic [PER_W_L-1:0] sys_per; // current system period in hclk cycles

	// --------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------
	// system period for a select and factor, in hclk cycles
	function automatic logic [PER_W_L-1:0] sys_period(input logic [1:0] s, input logic f);
		logic [PER_W_L-1:0] p;
		p = PER_W_L'(OSC_DIV);
		if (s == scsm_pkg::SEL_MULT) begin
			p = f ? PER_W_L'(OSC_DIV / scsm_pkg::MULT_4X) : PER_W_L'(OSC_DIV / scsm_pkg::MULT_2X);
		end else if (s == scsm_pkg::SEL_SLOW) begin
			p = PER_W_L'(OSC_DIV * scsm_pkg::SLOW_DIV);
		end
		return p;
	endfunction

	// a select change is legal only to or from divide-by-4
	function automatic logic sel_ok(input logic [1:0] cur, input logic [1:0] nw, input logic mult_ok);
		logic ok;
		ok = 1'b0;
		if (nw == cur) begin // no change
			ok = 1'b1;
		end else if (nw == scsm_pkg::SEL_RSVD) begin
			ok = 1'b0;
		end else if (nw == scsm_pkg::SEL_MULT) begin
			ok = (cur == scsm_pkg::SEL_DIV4) && mult_ok;
		end else if (nw == scsm_pkg::SEL_SLOW) begin
			ok = (cur == scsm_pkg::SEL_DIV4);
		end else begin // back to divide-by-4
			ok = 1'b1;
		end
		return ok;
	endfunction

	// --------------------------------------------------------------
	// clock dividers and lock counters
	// --------------------------------------------------------------
	// oscillator model: one tick per external clock cycle
	scsm_tick_div #(.W(PER_W_L)) u_osc (
		.hclk    (hclk),
		.hresetn (hresetn),
		.period  (PER_W_L'(OSC_DIV)),
		.tick    (osc_tick)
	);

	assign sys_per = sys_period(r.sel_eff, r.factor);

	// system clock; period change waits for a boundary
	scsm_tick_div #(.W(PER_W_L)) u_sys (
		.hclk    (hclk),
		.hresetn (hresetn),
		.period  (sys_per),
		.tick    (sys_tick)
	);

	// multiplier lock time
	scsm_lock_cnt #(.COUNT(LOCK_CYCLES)) u_rdy (
		.hclk    (hclk),
		.hresetn (hresetn),
		.start   (rdy_start),
		.clear   (rdy_clear),
		.step    (osc_tick),
		.busy    (),
		.done    (rdy_done),
		.fin     (rdy_fin)
	);

	// ring oscillator switchback after stop-mode exit
	scsm_lock_cnt #(.COUNT(LOCK_CYCLES)) u_ring (
		.hclk    (hclk),
		.hresetn (hresetn),
		.start   (ring_exit),
		.clear   (1'b0),
		.step    (osc_tick),
		.busy    (ring_busy),
		.done    (),
		.fin     (ring_fin)
	);

	// --------------------------------------------------------------
	// next-state logic: bus, select lock, sequence, events
	// --------------------------------------------------------------
	always_comb begin
		logic                       acc;     // address phase taken
		logic                       rd_ist;  // read of status clears it
		logic                       rej;     // select write refused
		logic [1:0]                 w_sel;   // written select
		logic                       w_en;    // written enable
		logic                       w_fac;   // written factor
		logic [1:0]                 sel_aft; // select after this write
		logic [scsm_pkg::IRQ_W-1:0] ev;      // events this cycle
		acc = 1'b0;
		rd_ist = 1'b0;
		rej = 1'b0;
		w_sel = hwdata[scsm_pkg::PMR_SEL_HI:scsm_pkg::PMR_SEL_LO];
		w_en = hwdata[scsm_pkg::PMR_ENA_BIT];
		w_fac = hwdata[scsm_pkg::PMR_FAC_BIT];
		sel_aft = r.sel;
		ev = '0;
		rdy_start = 1'b0;
		rdy_clear = 1'b0;
		next_r = r;
		next_r.dp_wr = 1'b0;

		// machine cycle: every fourth system tick
		next_r.mach_tick = 1'b0;
		if (sys_tick) begin
			next_r.mcnt = r.mcnt + 2'h1;
			if (r.mcnt == scsm_pkg::MC_LAST) begin
				next_r.mach_tick = 1'b1;
			end
		end
		// written select reaches the clock at the machine cycle boundary
		if (r.mach_tick) begin
			next_r.sel_eff = r.sel;
		end

		// address phase; only word transfers are acted on
		acc = hsel && htrans[1] && hready && (hsize == scsm_pkg::HSIZE_WORD);
		if (acc && hwrite) begin
			next_r.dp_wr = 1'b1;
			next_r.dp_addr = haddr[7:0];
		end else if (acc) begin // read: data captured now, shown in data phase
			next_r.rdata = '0;
			if (haddr[7:0] == scsm_pkg::ADDR_PMR) begin
				next_r.rdata[scsm_pkg::PMR_SEL_HI:scsm_pkg::PMR_SEL_LO] = r.sel;
				next_r.rdata[scsm_pkg::PMR_ENA_BIT] = r.mult_en;
				next_r.rdata[scsm_pkg::PMR_FAC_BIT] = r.factor;
			end else if (haddr[7:0] == scsm_pkg::ADDR_EXF) begin
				next_r.rdata[scsm_pkg::EXF_RDY_BIT] = rdy_done;
				next_r.rdata[scsm_pkg::EXF_RNG_BIT] = ring_busy;
			end else if (haddr[7:0] == scsm_pkg::ADDR_IST) begin
				next_r.rdata[scsm_pkg::IRQ_W-1:0] = r.ist;
				rd_ist = 1'b1;
			end else if (haddr[7:0] == scsm_pkg::ADDR_IMK) begin
				next_r.rdata[scsm_pkg::IRQ_W-1:0] = r.imask;
			end
		end

		// data phase of a write
		if (r.dp_wr && (r.dp_addr == scsm_pkg::ADDR_PMR)) begin
			if (sel_ok(r.sel, w_sel, (r.seq == scsm_pkg::SEQ_ARMED) && rdy_done)) begin
				next_r.sel = w_sel;
				sel_aft = w_sel;
			end else begin // field keeps its old value
				rej = 1'b1;
			end
			if (!w_en) begin
				// drop the multiplier only when neither the select after this write nor the select in force is 00
				if ((sel_aft != scsm_pkg::SEL_MULT) && (r.sel_eff != scsm_pkg::SEL_MULT)) begin
					next_r.mult_en = 1'b0;
					next_r.factor = w_fac;
					if ((r.seq == scsm_pkg::SEQ_ENCLR) || (r.seq == scsm_pkg::SEQ_FACT)) begin
						next_r.seq = scsm_pkg::SEQ_FACT;
					end else if ((r.sel == scsm_pkg::SEL_DIV4) && !ring_busy) begin
						next_r.seq = scsm_pkg::SEQ_ENCLR;
					end else begin
						next_r.seq = scsm_pkg::SEQ_IDLE;
					end
				end
			end else if (!r.mult_en) begin
				next_r.mult_en = 1'b1;
				if ((r.seq == scsm_pkg::SEQ_FACT) && (r.sel == scsm_pkg::SEL_DIV4) && !ring_busy) begin
					next_r.seq = scsm_pkg::SEQ_ARMED;
					rdy_start = 1'b1;
				end else begin // out of order: select 00 refused until enable is cleared and the sequence rerun
					next_r.seq = scsm_pkg::SEQ_IDLE;
				end
			end
		end else if (r.dp_wr && (r.dp_addr == scsm_pkg::ADDR_IMK)) begin
			next_r.imask = hwdata[scsm_pkg::IRQ_W-1:0];
		end
		// leaving the armed state drops the ready flag
		if ((r.seq == scsm_pkg::SEQ_ARMED) && (next_r.seq != scsm_pkg::SEQ_ARMED)) begin
			rdy_clear = 1'b1;
		end

		// sticky events; a new event wins over the read that clears
		ev[scsm_pkg::IRQ_RDY] = rdy_fin;
		ev[scsm_pkg::IRQ_RNG] = ring_fin;
		ev[scsm_pkg::IRQ_REJ] = rej;
		next_r.ist = (rd_ist ? '0 : r.ist) | ev;
		next_r.irq = |(next_r.ist & next_r.imask);
	end

	// --------------------------------------------------------------
	// state register
	// --------------------------------------------------------------
	// reset leaves divide-by-4 in force, multiplier off
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r <= '0;
			r.sel <= scsm_pkg::SEL_DIV4;
			r.sel_eff <= scsm_pkg::SEL_DIV4;
			r.seq <= scsm_pkg::SEQ_IDLE;
		end else begin
			r <= next_r;
		end
	end

	// --------------------------------------------------------------
	// outputs
	// --------------------------------------------------------------
	assign hreadyout        = 1'b1; // zero wait states
	assign hresp            = 1'b0; // always OKAY
	assign hrdata           = r.rdata;
	assign sys_clk_tick     = sys_tick;
	assign timer_base_tick  = sys_tick;
	assign machine_tick     = r.mach_tick;
	assign clock_source_sel = r.sel_eff;
	assign multiplier_on    = r.mult_en;
	assign irq              = r.irq;

endmodule

//--- dv/scsm_monitor.sv
// assertion checker for the clock select block, bound to its top module
`timescale 1ns/1ns
module scsm_monitor #(
	parameter int unsigned OSC_DIV = 16
) (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic        osc_tick,
	input wire logic        sys_clk_tick,
	input wire logic        timer_base_tick,
	input wire logic        machine_tick,
	input wire logic [1:0]  clock_source_sel,
	input wire logic        multiplier_on
);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	localparam int OD = OSC_DIV; // oscillator period in hclk cycles
	logic [2:0] sc;              // system ticks since last machine tick
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// count system ticks, restart at each machine tick
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sc <= 3'h0;
		end else if (machine_tick) begin
			sc <= 3'h0;
		end else if (sys_clk_tick) begin
			sc <= sc + 3'h1;
		end
	end
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	property p_bus; hreadyout && !hresp; endproperty
	property p_mtick; sc <= 3'h4; endproperty
	property p_timer; timer_base_tick == sys_clk_tick; endproperty
	property p_rsvd; clock_source_sel != scsm_pkg::SEL_RSVD; endproperty
	property p_path;
		$changed(clock_source_sel) |->
			(clock_source_sel == scsm_pkg::SEL_DIV4 || $past(clock_source_sel) == scsm_pkg::SEL_DIV4);
	endproperty
	property p_at_mc; $changed(clock_source_sel) |-> ($past(machine_tick) || $past(machine_tick, 2)); endproperty
	property p_mult; clock_source_sel == scsm_pkg::SEL_MULT |-> multiplier_on; endproperty
	property p_osc; osc_tick |-> ##OD osc_tick; endproperty
	property p_glitch; sys_clk_tick |=> !sys_clk_tick [*3]; endproperty
	property p_rdata;
		$changed(hrdata) |-> $past(hsel && htrans[1] && !hwrite && hready && hsize == scsm_pkg::HSIZE_WORD);
	endproperty
	a_bus: assert property (p_bus) else $error("bus answer not ready or okay");
	a_mtick: assert property (p_mtick) else $error("machine tick missed fourth system tick");
	a_timer: assert property (p_timer) else $error("timer base differs from system tick");
	a_rsvd: assert property (p_rsvd) else $error("reserved select in force");
	a_path: assert property (p_path) else $error("select moved without divide-by-4");
	a_at_mc: assert property (p_at_mc) else $error("select changed off machine cycle");
	a_mult: assert property (p_mult) else $error("multiplier select with enable clear");
	a_osc: assert property (p_osc) else $error("oscillator tick period wrong");
	a_glitch: assert property (p_glitch) else $error("system tick shorter than fastest period");
	a_rdata: assert property (p_rdata) else $error("read data moved without read");
	c_mult: cover property (clock_source_sel == scsm_pkg::SEL_MULT);
	c_slow: cover property (clock_source_sel == scsm_pkg::SEL_SLOW);
	c_read: cover property ($changed(hrdata));
endmodule
bind scsm_top scsm_monitor #(.OSC_DIV(OSC_DIV)) u_mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.hrdata(hrdata), .osc_tick(osc_tick), .sys_clk_tick(sys_clk_tick), .timer_base_tick(timer_base_tick),
	.machine_tick(machine_tick), .clock_source_sel(clock_source_sel), .multiplier_on(multiplier_on));

//--- dv/scsm_ring_src.sv
// partner model: stop-mode exit source that pulses the ring event
`timescale 1ns/1ns
module scsm_ring_src (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic fire,
	output logic      ring_exit
);
	logic fire_q; // last fire level, for edge detect
	// one-cycle exit pulse per request, so a held request is one event
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fire_q    <= 1'b0;
			ring_exit <= 1'b0;
		end else begin
			fire_q    <= fire;
			ring_exit <= fire & ~fire_q;
		end
	end
endmodule

//--- dv/tb_top.sv
// self-checking bench for the clock select block
`timescale 1ns/1ns
module tb_top;
	// ------------------------------------------------------------
	// signals and model state
	// ------------------------------------------------------------
	localparam int unsigned OSC  = 16; // 7.8 MHz source, 4x stays under 40 MHz
	localparam int unsigned LOCK = 16; // short lock count keeps the run brief
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic        fire = 1'b0;
	logic        hreadyout, hresp, osc_tick, sys_clk_tick, timer_base_tick, machine_tick, multiplier_on, irq;
	logic        ring_exit;
	logic [31:0] hrdata;
	logic [1:0]  clock_source_sel;
	logic [31:0] r;
	int          err_total = 0;
	int          compares = 0;
	int unsigned seed = 81347;
	int          m_sel = 2, m_en = 0, m_fac = 0, m_ist = 0, m_arm = 0, m_rdy = 0;
	int          p, n;
	logic [7:0]  v;
	always #4 hclk = ~hclk;
	scsm_top #(.OSC_DIV(OSC), .LOCK_CYCLES(LOCK)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ring_exit(ring_exit), .osc_tick(osc_tick),
		.sys_clk_tick(sys_clk_tick), .timer_base_tick(timer_base_tick), .machine_tick(machine_tick),
		.clock_source_sel(clock_source_sel), .multiplier_on(multiplier_on), .irq(irq));
	scsm_ring_src u_ring (.hclk(hclk), .hresetn(hresetn), .fire(fire), .ring_exit(ring_exit));
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic int unsigned xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// expected power mode word from the model
	function automatic logic [31:0] pmr_exp();
		return {24'h0, 2'(m_sel), 1'b0, 1'(m_en), 1'(m_fac), 3'h0};
	endfunction
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one single word transfer, address then data phase, never open-ended
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		int k;
		int c;
		@(posedge hclk); // address phase always launched just after a rising edge
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		hsize <= scsm_pkg::HSIZE_WORD;
		for (k = 0; k < 2; k++) begin
			c = 0;
			do begin
				@(posedge hclk);
				c++;
			end while (hreadyout !== 1'b1 && c < 100);
			if (c >= 100) begin
				err_total++;
				end_of_test();
			end
			if (k == 0) begin
				htrans <= 2'h0;
				hsel <= 1'b0;
				hwdata <= {24'h0, d};
			end
		end
		r = hrdata;
	endtask
	// write with the reference model of select acceptance run first
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		int q;
		q = d[7:6];
		if (a == scsm_pkg::ADDR_PMR) begin
			if (q == m_sel || q == 2 || (q == 3 && m_sel == 2) || (q == 0 && m_sel == 2 && m_arm && m_rdy)) begin
				m_sel = q;
			end else begin
				m_ist |= 4;
			end
			if (d[4]) begin
				m_en = 1;
			end else if (m_sel != 0) begin
				m_en = 0;
				m_fac = d[3];
				m_arm = 0;
				m_rdy = 0;
			end
		end
		xfer(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 8'h0);
		chk(r, exp);
	endtask
	// status read clears every sticky bit in the model too
	task automatic ist();
		rd(scsm_pkg::ADDR_IST, m_ist);
		m_ist = 0;
	endtask
	task automatic wait_sel(input logic [1:0] s);
		int c;
		c = 0;
		// slow mode machine cycle alone is 16384 hclk cycles long
		while (clock_source_sel !== s && c < 20000) begin
			@(negedge hclk);
			c++;
		end
		if (c >= 20000) begin
			err_total++;
			end_of_test();
		end
		chk({30'h0, clock_source_sel}, {30'h0, s});
	endtask
	// period between the second and third tick, old period may finish first
	task automatic per(input bit m, output int t);
		int k;
		int c;
		t = 0;
		k = 0;
		c = 0;
		while (k < 3 && c < 20000) begin
			@(negedge hclk);
			c++;
			t++;
			if ((m ? machine_tick : sys_clk_tick) === 1'b1) begin
				k++;
				if (k < 3) t = 0;
			end
		end
		if (c >= 20000) begin
			err_total++;
			end_of_test();
		end
	endtask
	// poll the flag word until bit b equals e, within a bounded count
	task automatic poll(input int b, input logic e);
		n = 0;
		do begin
			xfer(1'b0, scsm_pkg::ADDR_EXF, 8'h0);
			n++;
		end while (r[b] !== e && n < 200);
		if (r[b] !== e) begin
			err_total++;
			end_of_test();
		end
	endtask
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(scsm_pkg::ADDR_PMR, 32'h80);
		rd(scsm_pkg::ADDR_EXF, 32'h0);
		rd(scsm_pkg::ADDR_IMK, 32'h0);
		rd(8'h10, 32'h0);
		chk({31'h0, multiplier_on}, 32'h0);
		per(1'b0, p);
		chk(p, OSC);
		per(1'b1, p);
		chk(p, 4 * OSC);
		$display("done: reset and rates");
		repeat (4) begin
			v = 8'(xs());
			wr(scsm_pkg::ADDR_IMK, v);
			rd(scsm_pkg::ADDR_IMK, {29'h0, v[2:0]});
		end
		wr(scsm_pkg::ADDR_IMK, 8'h7);
		// enable set with no clear and factor step first: out of order
		wr(scsm_pkg::ADDR_PMR, 8'h90);
		repeat (LOCK * OSC + 64) @(negedge hclk);
		rd(scsm_pkg::ADDR_EXF, 32'h0);
		wr(scsm_pkg::ADDR_PMR, 8'h10);
		rd(scsm_pkg::ADDR_PMR, pmr_exp());
		ist();
		for (int i = 0; i < 2; i++) begin
			wr(scsm_pkg::ADDR_PMR, (i == 0) ? 8'h40 : 8'h00);
			rd(scsm_pkg::ADDR_PMR, pmr_exp());
			chk({31'h0, irq}, 32'h1);
			ist();
			repeat (2) @(negedge hclk);
			chk({31'h0, irq}, 32'h0);
		end
		$display("done: refused selects");
		for (int f = 0; f < 2; f++) begin
			wr(scsm_pkg::ADDR_PMR, 8'h80);
			wr(scsm_pkg::ADDR_PMR, 8'h80 | 8'(f * 8));
			rd(scsm_pkg::ADDR_EXF, 32'h0);
			wr(scsm_pkg::ADDR_PMR, 8'h90 | 8'(f * 8));
			m_arm = 1;
			poll(4, 1'b1);
			chk(r, 32'h10);
			m_rdy = 1;
			m_ist |= 1;
			ist();
			wr(scsm_pkg::ADDR_PMR, 8'h10 | 8'(f * 8));
			wait_sel(2'h0);
			chk({31'h0, multiplier_on}, 32'h1);
			per(1'b0, p);
			chk(p, (f == 1) ? OSC / 4 : OSC / 2);
			per(1'b1, p);
			chk(p, (f == 1) ? OSC : 2 * OSC);
			wr(scsm_pkg::ADDR_PMR, 8'h90 | 8'(f * 8));
			wait_sel(2'h2);
			rd(scsm_pkg::ADDR_PMR, pmr_exp());
		end
		$display("done: multiplier engage and leave");
		wr(scsm_pkg::ADDR_PMR, 8'hc0);
		wait_sel(2'h3);
		per(1'b0, p);
		chk(p, OSC * 256);
		wr(scsm_pkg::ADDR_PMR, 8'h00);
		rd(scsm_pkg::ADDR_PMR, pmr_exp());
		ist();
		wr(scsm_pkg::ADDR_PMR, 8'h80);
		wait_sel(2'h2);
		$display("done: slow clock mode");
		@(posedge hclk);
		fire <= 1'b1;
		repeat (3) @(posedge hclk);
		rd(scsm_pkg::ADDR_EXF, 32'h4);
		poll(2, 1'b0);
		chk(r, 32'h0);
		m_ist |= 2;
		ist();
		$display("done: ring switchback");
		end_of_test();
	end
endmodule
